/* File: core/esf_pkg.sv */
// Purpose: Shared constants and types of the encoder speed feedback block
// Assumes: 200 MHz system clock, one clock domain
// Notes: Feedback values are signed, 0.01 % per bit; trims and ratio are 4.12 fixed point
package esf_pkg;
  localparam int CLK_HZ = 200_000_000;
  localparam int GATE_MS = 10;
  localparam int GATE_CYC_DEF = CLK_HZ / 1000 * GATE_MS;
  localparam int SEC_PER_MIN = 60;
  localparam int PCT_FULL = 10000;
  localparam int IR_DIV = 10000;
  localparam int FIX_FRAC = 12;
  localparam int DIV_W = 48;
  localparam int CNT_W = 24;
  localparam int FB_W = 16;
  localparam int OUT_W = 22;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_LINES = 8'h04;
  localparam logic [7:0] OFS_RATIO = 8'h08;
  localparam logic [7:0] OFS_MAX_RPM = 8'h0C;
  localparam logic [7:0] OFS_IR_COMP = 8'h10;
  localparam logic [7:0] OFS_FLD_TRIM = 8'h14;
  localparam logic [7:0] OFS_AV_TRIM = 8'h18;
  localparam logic [7:0] OFS_TACHO_TRIM = 8'h1C;
  localparam logic [7:0] OFS_ENC_RPM = 8'h20;
  localparam logic [7:0] OFS_MOTOR_PCT = 8'h24;
  localparam logic [7:0] OFS_STATUS = 8'h28;

  // Control register fields
  localparam int CTRL_QUAD = 0;
  localparam int CTRL_INV = 1;
  localparam int CTRL_LOCK = 2;
  localparam int CTRL_FB_LSB = 4;
  localparam int CTRL_W = 7;

  // Reset values
  localparam logic [CTRL_W-1:0] RST_CTRL = 7'h00;
  localparam logic [15:0] RST_LINES = 16'h0400;
  localparam logic [15:0] TRIM_ONE = 16'h1000;
  localparam logic [15:0] RST_MAX_RPM = 16'h07D0;
  localparam logic [15:0] RST_IR_COMP = 16'h0000;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    FB_ARM_VOLT = 3'h0,
    FB_TACHO = 3'h1,
    FB_ENC = 3'h2,
    FB_ENC_AV = 3'h3,
    FB_ENC_TACHO = 3'h4
  } esf_fb_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_DIV_RPM = 2'h1,
    ST_DIV_PCT = 2'h3
  } esf_state_e;
endpackage

/* File: core/esf_enc_if.sv */
// Purpose: Carries decoded encoder events from the input stage to the core
// Assumes: Both ends on clk_sys_i
// Notes: pulse is one cycle per full high/low cycle of the A train
`timescale 1ns/100ps
interface esf_enc_if;
  logic quad_en;
  logic pulse;
  logic dir_raw;
  modport dec (input quad_en, output pulse, output dir_raw);
  modport core (output quad_en, input pulse, input dir_raw);
endinterface

/* File: core/esf_decoder.sv */
// Purpose: Encoder input synchroniser and pulse/quadrature direction decoder
// Assumes: Inputs asynchronous to clk_sys_i
// Notes: No filter beyond the synchroniser so short pulses survive
`timescale 1ns/100ps
module esf_decoder
  import esf_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Encoder pins: A train / pulse, B train / direction level
  input wire logic enc_a_i,
  input wire logic enc_b_i,
  // Decoded events
  esf_enc_if.dec enc
);
  logic [1:0] sync1_r;
  logic [1:0] sync2_r;
  logic a_prev_r;
  logic pulse_r;
  logic dir_r;
  logic a_prev_nxt;
  logic pulse_nxt;
  logic dir_nxt;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_sync
      always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
          sync1_r[g] <= 1'b0;
          sync2_r[g] <= 1'b0;
        end else begin
          sync1_r[g] <= (g == 0) ? enc_a_i : enc_b_i;
          sync2_r[g] <= sync1_r[g];
        end
      end
    end
  endgenerate

  always_comb begin
    a_prev_nxt = sync2_r[0];
    pulse_nxt = sync2_r[0] & ~a_prev_r;
    dir_nxt = dir_r;
    if (!enc.quad_en) begin
      dir_nxt = sync2_r[1];
    end else if (pulse_nxt) begin
      // A rising while B low means A leads
      dir_nxt = ~sync2_r[1];
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      a_prev_r <= 1'b0;
      pulse_r <= 1'b0;
      dir_r <= 1'b1;
    end else begin
      a_prev_r <= a_prev_nxt;
      pulse_r <= pulse_nxt;
      dir_r <= dir_nxt;
    end
  end

  assign enc.pulse = pulse_r;
  assign enc.dir_raw = dir_r;
endmodule

/* File: core/esf_top.sv */
// Purpose: Encoder speed feedback, monitor scaling and analog feedback trims
// Assumes: AXI4-Lite register slave, single clock, analog values already digitised
// Notes: Speed is measured by counting pulses over a fixed gate window
//
// Summary of operation
// - Pulse mode: count pulses, direction level
// - Quadrature: A leads forward, B leads reverse
// - Sign inversion acts in both modes
// - Types 3/4 single train: analog sign
// - Accept very short pulses, no heavy filter
// - Lines setting is cycles per revolution
// - Gear ratio multiplies encoder speed
// - Shaft percent 100 at full speed
// - Monitors from pulses only, zero without
// - Drop compensation with armature feedback, weakening
// - Subtract current-proportional term from armature
// - Field trim at least unity, neutral one
// - Armature trim at least unity, neutral one
// - Tacho trim at least unity, neutral one
//
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module esf_top
  import esf_pkg::*;
#(
  parameter int GATE_CYC = GATE_CYC_DEF
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Encoder pins
  input wire logic enc_a_i,
  input wire logic enc_b_i,
  // Analog feedback and drive state
  input wire logic signed [FB_W-1:0] arm_volt_i,
  input wire logic signed [FB_W-1:0] arm_cur_i,
  input wire logic signed [FB_W-1:0] fld_cur_i,
  input wire logic signed [FB_W-1:0] tacho_i,
  input wire logic fld_weak_i,
  // Feedback results
  output logic signed [OUT_W-1:0] fld_fb_o,
  output logic signed [OUT_W-1:0] av_fb_o,
  output logic signed [OUT_W-1:0] tacho_fb_o,
  output logic signed [31:0] enc_rpm_o,
  output logic signed [31:0] motor_pct_o,
  output logic dir_fwd_o,
  output logic dir_pin_free_o,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam logic [DIV_W-1:0] K_RPM = DIV_W'(longint'(SEC_PER_MIN) * CLK_HZ / GATE_CYC);
  localparam logic [31:0] GATE_LAST = 32'(GATE_CYC - 1);
  localparam logic [5:0] DIV_STEPS = 6'(DIV_W);

  generate
    if (GATE_CYC < 4 * DIV_W || (longint'(SEC_PER_MIN) * CLK_HZ) % GATE_CYC != 0) begin : g_chk
      $error("GATE_CYC too short or not a divisor of one minute of clocks");
    end
  endgenerate

  function automatic logic reg_ok(input logic [7:0] a, input logic wr);
    reg_ok = (a[1:0] == 2'h0) && (a <= (wr ? OFS_TACHO_TRIM : OFS_STATUS));
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  esf_enc_if enc ();

  esf_decoder i_esf_decoder (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .enc_a_i(enc_a_i),
    .enc_b_i(enc_b_i),
    .enc(enc.dec)
  );

  // Register file and bus state
  logic [CTRL_W-1:0] ctrl_r, ctrl_nxt;
  logic [15:0] lines_r, lines_nxt, ratio_r, ratio_nxt, max_rpm_r, max_rpm_nxt;
  logic [15:0] ir_r, ir_nxt;
  logic [15:0] trim_r [3];
  logic [15:0] trim_nxt [3];
  logic aw_ok_r, aw_ok_nxt, w_ok_r, w_ok_nxt, bvalid_r, bvalid_nxt;
  logic [7:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [15:0] wr16;
  esf_fb_e fb_type;
  logic busy;

  assign fb_type = esf_fb_e'(ctrl_r[CTRL_FB_LSB +: 3]);
  assign enc.quad_en = ctrl_r[CTRL_QUAD];

  always_comb begin
    ctrl_nxt = ctrl_r;
    lines_nxt = lines_r;
    ratio_nxt = ratio_r;
    max_rpm_nxt = max_rpm_r;
    ir_nxt = ir_r;
    trim_nxt = trim_r;
    aw_ok_nxt = aw_ok_r;
    w_ok_nxt = w_ok_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    wr16 = 16'h0000;
    if (s_axi_awvalid && !aw_ok_r) begin
      aw_ok_nxt = 1'b1;
      awaddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_ok_r) begin
      w_ok_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (aw_ok_r && w_ok_r && !bvalid_r) begin
      aw_ok_nxt = 1'b0;
      w_ok_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = reg_ok(awaddr_r, 1'b1) ? RESP_OKAY : RESP_SLVERR;
      case (awaddr_r)
        OFS_CTRL: begin
          ctrl_nxt = wstrb_r[0] ? wdata_r[CTRL_W-1:0] : ctrl_r;
        end
        OFS_LINES: begin
          lines_nxt = merge16(lines_r, wdata_r, wstrb_r);
        end
        OFS_RATIO: begin
          ratio_nxt = merge16(ratio_r, wdata_r, wstrb_r);
        end
        OFS_MAX_RPM: begin
          max_rpm_nxt = merge16(max_rpm_r, wdata_r, wstrb_r);
        end
        OFS_IR_COMP: begin
          ir_nxt = merge16(ir_r, wdata_r, wstrb_r);
        end
        OFS_FLD_TRIM, OFS_AV_TRIM, OFS_TACHO_TRIM: begin
          wr16 = merge16(trim_r[awaddr_r[3:2] - 2'h1], wdata_r, wstrb_r);
          // Trims never go below unity; writes take effect while running
          trim_nxt[awaddr_r[3:2] - 2'h1] = (wr16 < TRIM_ONE) ? TRIM_ONE : wr16;
        end
        default: begin
        end
      endcase
    end
    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid && !rvalid_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = reg_ok(s_axi_araddr, 1'b0) ? RESP_OKAY : RESP_SLVERR;
      case (s_axi_araddr)
        OFS_CTRL: rdata_nxt = 32'(ctrl_r);
        OFS_LINES: rdata_nxt = 32'(lines_r);
        OFS_RATIO: rdata_nxt = 32'(ratio_r);
        OFS_MAX_RPM: rdata_nxt = 32'(max_rpm_r);
        OFS_IR_COMP: rdata_nxt = 32'(ir_r);
        OFS_FLD_TRIM: rdata_nxt = 32'(trim_r[0]);
        OFS_AV_TRIM: rdata_nxt = 32'(trim_r[1]);
        OFS_TACHO_TRIM: rdata_nxt = 32'(trim_r[2]);
        OFS_ENC_RPM: rdata_nxt = enc_rpm_o;
        OFS_MOTOR_PCT: rdata_nxt = motor_pct_o;
        OFS_STATUS: rdata_nxt = {29'h0, dir_pin_free_o, busy, dir_fwd_o};
        default: rdata_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_r <= RST_CTRL;
      lines_r <= RST_LINES;
      ratio_r <= TRIM_ONE;
      max_rpm_r <= RST_MAX_RPM;
      ir_r <= RST_IR_COMP;
      trim_r <= '{TRIM_ONE, TRIM_ONE, TRIM_ONE};
      aw_ok_r <= 1'b0;
      w_ok_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= RESP_OKAY;
    end else begin
      ctrl_r <= ctrl_nxt;
      lines_r <= lines_nxt;
      ratio_r <= ratio_nxt;
      max_rpm_r <= max_rpm_nxt;
      ir_r <= ir_nxt;
      trim_r <= trim_nxt;
      aw_ok_r <= aw_ok_nxt;
      w_ok_r <= w_ok_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  assign s_axi_awready = !aw_ok_r;
  assign s_axi_wready = !w_ok_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // Speed measurement: gate window, then shared serial divider
  esf_state_e st_r, st_nxt;
  logic [31:0] gate_r, gate_nxt;
  logic [CNT_W-1:0] pcnt_r, pcnt_nxt;
  logic [DIV_W-1:0] num_r, num_nxt;
  logic [32:0] rem_r, rem_nxt, rem_sh;
  logic [31:0] den_r, den_nxt, rpm_abs_r, rpm_abs_nxt;
  logic [5:0] step_r, step_nxt;
  logic neg_r, neg_nxt, fwd_r, fwd_nxt;
  logic signed [31:0] rpm_r, rpm_nxt, pct_r, pct_nxt;
  logic analog_sign, lock_free;

  // Single-train encoder in combined types leaves the direction pin unused unless CTRL_LOCK is set
  assign lock_free = !ctrl_r[CTRL_QUAD] && !ctrl_r[CTRL_LOCK]
                     && (fb_type == FB_ENC_AV || fb_type == FB_ENC_TACHO);
  assign analog_sign = (fb_type == FB_ENC_AV) ? !arm_volt_i[FB_W-1] : !tacho_i[FB_W-1];
  assign busy = (st_r != ST_IDLE);

  always_comb begin
    st_nxt = st_r;
    gate_nxt = (gate_r == GATE_LAST) ? 32'h0 : gate_r + 32'h1;
    pcnt_nxt = pcnt_r;
    num_nxt = num_r;
    rem_nxt = rem_r;
    den_nxt = den_r;
    step_nxt = step_r;
    neg_nxt = neg_r;
    rpm_abs_nxt = rpm_abs_r;
    rpm_nxt = rpm_r;
    pct_nxt = pct_r;
    fwd_nxt = lock_free ? analog_sign : enc.dir_raw ^ ctrl_r[CTRL_INV];
    rem_sh = {rem_r[31:0], num_r[DIV_W-1]};
    if (enc.pulse && pcnt_r != {CNT_W{1'b1}}) begin
      pcnt_nxt = pcnt_r + CNT_W'(1);
    end
    case (st_r)
      ST_IDLE: begin
        if (gate_r == GATE_LAST) begin
          // Pulse count only, whatever feedback type is chosen
          num_nxt = DIV_W'(pcnt_nxt) * K_RPM;
          den_nxt = 32'(lines_r);
          rem_nxt = 33'h0;
          step_nxt = DIV_STEPS;
          neg_nxt = !fwd_r;
          pcnt_nxt = '0;
          st_nxt = ST_DIV_RPM;
        end
      end
      ST_DIV_RPM, ST_DIV_PCT: begin
        if (step_r != 6'h0) begin
          step_nxt = step_r - 6'h1;
          if (rem_sh >= {1'b0, den_r}) begin
            rem_nxt = rem_sh - {1'b0, den_r};
            num_nxt = {num_r[DIV_W-2:0], 1'b1};
          end else begin
            rem_nxt = rem_sh;
            num_nxt = {num_r[DIV_W-2:0], 1'b0};
          end
        end else if (st_r == ST_DIV_RPM) begin
          rpm_abs_nxt = (den_r == 32'h0) ? 32'h0 : num_r[31:0];
          rpm_nxt = neg_r ? -$signed(rpm_abs_nxt) : $signed(rpm_abs_nxt);
          // Ratio is a plain multiplier, 100 % equals full-scale rpm
          num_nxt = DIV_W'((64'(rpm_abs_nxt) * ratio_r * PCT_FULL) >> FIX_FRAC);
          den_nxt = 32'(max_rpm_r);
          rem_nxt = 33'h0;
          step_nxt = DIV_STEPS;
          st_nxt = ST_DIV_PCT;
        end else begin
          pct_nxt = (den_r == 32'h0) ? 32'sh0 :
                    (neg_r ? -$signed(num_r[31:0]) : $signed(num_r[31:0]));
          st_nxt = ST_IDLE;
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= ST_IDLE;
      gate_r <= 32'h0;
      pcnt_r <= '0;
      num_r <= '0;
      rem_r <= 33'h0;
      den_r <= 32'h0;
      step_r <= 6'h0;
      neg_r <= 1'b0;
      rpm_abs_r <= 32'h0;
      rpm_r <= 32'sh0;
      pct_r <= 32'sh0;
      fwd_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      gate_r <= gate_nxt;
      pcnt_r <= pcnt_nxt;
      num_r <= num_nxt;
      rem_r <= rem_nxt;
      den_r <= den_nxt;
      step_r <= step_nxt;
      neg_r <= neg_nxt;
      rpm_abs_r <= rpm_abs_nxt;
      rpm_r <= rpm_nxt;
      pct_r <= pct_nxt;
      fwd_r <= fwd_nxt;
    end
  end

  assign enc_rpm_o = rpm_r;
  assign motor_pct_o = pct_r;
  assign dir_fwd_o = fwd_r;
  assign dir_pin_free_o = lock_free;

  // Analog paths: drop compensation then trims (0 field, 1 armature, 2 tacho)
  logic signed [FB_W+1:0] fb_in [3];
  logic signed [OUT_W-1:0] fb_nxt [3];
  logic signed [OUT_W-1:0] fb_r [3];
  logic signed [FB_W+1:0] ir_term;
  logic comp_on;

  assign comp_on = (fb_type == FB_ARM_VOLT) || fld_weak_i;
  // Zero at zero current, rises with current
  assign ir_term = comp_on ? (FB_W+2)'(32'(arm_cur_i) * $signed({1'b0, ir_r}) / IR_DIV)
                           : '0;
  assign fb_in[0] = (FB_W+2)'(fld_cur_i);
  assign fb_in[1] = (FB_W+2)'(arm_volt_i) - ir_term;
  assign fb_in[2] = (FB_W+2)'(tacho_i);

  genvar t;
  generate
    for (t = 0; t < 3; t++) begin : g_trim
      always_comb begin
        fb_nxt[t] = OUT_W'((40'(fb_in[t]) * $signed({1'b0, trim_r[t]})) >>> FIX_FRAC);
      end
      always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
          fb_r[t] <= '0;
        end else begin
          fb_r[t] <= fb_nxt[t];
        end
      end
    end
  endgenerate

  assign fld_fb_o = fb_r[0];
  assign av_fb_o = fb_r[1];
  assign tacho_fb_o = fb_r[2];
endmodule

/* File: verif/esf_assertions.sv */
// Purpose: Port-level checks of the encoder speed feedback block
// Assumes: One clock, async active-high reset
// Notes: Sees only esf_top ports; unused ports are left out
`timescale 1ns/100ps
module esf_assertions
  import esf_pkg::*;
#(
  parameter int GATE_CYC = GATE_CYC_DEF
) (
  // Clock, reset, encoder
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic enc_a_i,
  // Feedback
  input wire logic signed [FB_W-1:0] arm_volt_i, arm_cur_i, fld_cur_i, tacho_i,
  input wire logic signed [OUT_W-1:0] fld_fb_o, av_fb_o, tacho_fb_o,
  input wire logic signed [31:0] enc_rpm_o, motor_pct_o,
  // Register bus
  input wire logic [7:0] s_axi_awaddr, s_axi_araddr,
  input wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
  input wire logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
  input wire logic s_axi_rvalid, s_axi_rready,
  input wire logic [1:0] s_axi_bresp, s_axi_rresp,
  input wire logic [31:0] s_axi_rdata
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  logic a_r;
  logic a_nxt;
  logic [31:0] idle_r;
  logic [31:0] idle_nxt;
  logic wr_go;
  // Cycles since the A train last moved, saturating
  always_comb begin
    a_nxt = enc_a_i;
    idle_nxt = idle_r;
    if (enc_a_i != a_r) begin
      idle_nxt = '0;
    end else if (idle_r != 32'hFFFFFFFF) begin
      idle_nxt = idle_r + 32'h1;
    end
  end
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      a_r <= 1'b0;
      idle_r <= '0;
    end else begin
      a_r <= a_nxt;
      idle_r <= idle_nxt;
    end
  end
  assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data dropped early");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  wr_answer_a: assert property (wr_go |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
  rd_unmapped_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > OFS_STATUS
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read");
  wr_readonly_a: assert property (wr_go && s_axi_awaddr > OFS_TACHO_TRIM
    |-> ##[1:2] s_axi_bvalid && s_axi_bresp == RESP_SLVERR) else $error("bad write accepted");
  fld_floor_a: assert property (($stable(fld_cur_i) && fld_cur_i >= 0)[*3] |-> fld_fb_o >= fld_cur_i)
    else $error("field feedback below input");
  av_floor_a: assert property (($stable(arm_volt_i) && arm_volt_i >= 0 && arm_cur_i == 0)[*3]
    |-> av_fb_o >= arm_volt_i) else $error("armature feedback below input");
  tacho_floor_a: assert property (($stable(tacho_i) && tacho_i >= 0)[*3] |-> tacho_fb_o >= tacho_i)
    else $error("tacho feedback below input");
  rpm_idle_a: assert property (idle_r > 3 * GATE_CYC |-> enc_rpm_o == 0 && motor_pct_o == 0)
    else $error("speed not zero without pulses");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == RESP_SLVERR);
  cover property (enc_rpm_o < 0);
endmodule

bind esf_top esf_assertions #(.GATE_CYC(GATE_CYC)) i_esf_assertions (.*);

/* File: verif/esf_encoder_model.sv */
// Purpose: Behavioural shaft encoder driving the A and B pins
// Assumes: Pulse-with-direction or quadrature output
// Notes: Stands still while run_i is low
`timescale 1ns/100ps
module esf_encoder_model (
  // Control
  input wire logic run_i,
  input wire logic quad_i,
  input wire logic fwd_i,
  input wire logic [31:0] high_ns_i,
  // Encoder pins
  output logic enc_a_o,
  output logic enc_b_o
);
  // A 10 us cycle keeps the train at the frequency ceiling
  localparam int PER_NS = 10000;
  always begin
    if (!run_i) begin
      if (!quad_i) begin
        enc_a_o = 1'b0;
        enc_b_o = fwd_i;
      end
      #50;
    end else if (!quad_i) begin
      enc_b_o = fwd_i;
      enc_a_o = 1'b1;
      #(high_ns_i);
      enc_a_o = 1'b0;
      #(PER_NS - high_ns_i);
    end else begin
      // Forward: A leads B by a quarter cycle
      {enc_a_o, enc_b_o} = fwd_i ? 2'b10 : 2'b01;
      #(PER_NS / 4);
      {enc_a_o, enc_b_o} = 2'b11;
      #(PER_NS / 4);
      {enc_a_o, enc_b_o} = fwd_i ? 2'b01 : 2'b10;
      #(PER_NS / 4);
      {enc_a_o, enc_b_o} = 2'b00;
      #(PER_NS / 4);
    end
  end
endmodule

/* File: verif/encoder_speed_feedback_test.sv */
// Purpose: Self-checking bench for esf_top
// Assumes: 200 MHz clock, shortened gate window
// Notes: Encoder phase waits 2.75 windows per setting
`timescale 1ns/100ps
module encoder_speed_feedback_test
  import esf_pkg::*;
;
  localparam int GC = 4000;
  localparam int PULSES = GC * 5 / 10000;
  localparam int LN = 1000;
  localparam int MAXR = 6000;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic fld_weak_i = 1'b0;
  wire enc_a_i, enc_b_i, dir_fwd_o, dir_pin_free_o;
  logic signed [FB_W-1:0] arm_volt_i = '0, arm_cur_i = '0, fld_cur_i = '0, tacho_i = '0;
  wire signed [OUT_W-1:0] fld_fb_o, av_fb_o, tacho_fb_o;
  wire signed [31:0] enc_rpm_o, motor_pct_o;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  logic run = 0, quad = 0, fwd = 1;
  int high_ns = 5000;
  int num_errors = 0, samples_checked = 0, seed = 32'h7752FAF3;
  logic [7:0] ofs [8] = '{OFS_CTRL, OFS_LINES, OFS_RATIO, OFS_MAX_RPM, OFS_IR_COMP,
    OFS_FLD_TRIM, OFS_AV_TRIM, OFS_TACHO_TRIM};
  logic [15:0] rv [8] = '{16'h0000, RST_LINES, TRIM_ONE, RST_MAX_RPM, RST_IR_COMP,
    TRIM_ONE, TRIM_ONE, TRIM_ONE};
  // Fast train, so encoder-only types are fair; last entry takes the tacho sign
  logic [6:0] ctl [7] = '{7'h20, 7'h22, 7'h21, 7'h23, 7'h30, 7'h34, 7'h40};
  int sg [7] = '{1, -1, -1, 1, -1, 1, 1};
  logic fw [7] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
  logic [31:0] d, rn;
  logic [1:0] r;
  logic [15:0] t1, t2, t3;
  longint e;
  always #2.5 clk_sys_i = ~clk_sys_i;
  esf_top #(.GATE_CYC(GC)) i_esf_top (.*);
  esf_encoder_model i_esf_encoder_model (.run_i(run), .quad_i(quad), .fwd_i(fwd),
    .high_ns_i(high_ns), .enc_a_o(enc_a_i), .enc_b_o(enc_b_i));
  task automatic give_verdict();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    int n;
    @(posedge clk_sys_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 99; n++) begin
      @(posedge clk_sys_i);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n == 99) begin
      num_errors++;
      give_verdict();
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    int n;
    @(posedge clk_sys_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 99; n++) begin
      @(posedge clk_sys_i);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    v = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n == 99) begin
      num_errors++;
      give_verdict();
    end
  endtask
  function automatic longint trim(longint v, longint t);
    return (v * t) >>> FIX_FRAC;
  endfunction
  function automatic longint pct(longint rpm, longint ratio);
    return rpm * ratio / 4096 * PCT_FULL / MAXR;
  endfunction
  initial begin
    repeat (8) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      rd(ofs[i], d, r);
      check(d, {16'h0, rv[i]});
    end
    rd(8'h40, d, r);
    check({r, d}, {RESP_SLVERR, 32'h0});
    wr(OFS_ENC_RPM, 32'h1, r);
    check(r, RESP_SLVERR);
    wr(OFS_FLD_TRIM, 32'h0800, r);
    rd(OFS_FLD_TRIM, d, r);
    check(d, {16'h0, TRIM_ONE});
    // Trims rewritten while inputs keep moving
    for (int i = 0; i < 12; i++) begin
      rn = $random(seed);
      t1 = {4'h1, rn[11:0]};
      t2 = {4'h1, rn[23:12]};
      t3 = {4'h1, rn[31:24], rn[3:0]};
      wr(OFS_FLD_TRIM, {16'h0, t1}, r);
      wr(OFS_AV_TRIM, {16'h0, t2}, r);
      wr(OFS_TACHO_TRIM, {16'h0, t3}, r);
      rn = $random(seed);
      fld_cur_i <= rn[15:0];
      arm_volt_i <= rn[31:16];
      rn = $random(seed);
      tacho_i <= rn[15:0];
      arm_cur_i <= i[0] ? 16'sh0 : rn[31:16];
      repeat (4) @(posedge clk_sys_i);
      check(fld_fb_o, trim(fld_cur_i, t1));
      check(av_fb_o, trim(arm_volt_i, t2));
      check(tacho_fb_o, trim(tacho_i, t3));
    end
    wr(OFS_AV_TRIM, {16'h0, TRIM_ONE}, r);
    wr(OFS_IR_COMP, 32'd100, r);
    for (int i = 0; i < 3; i++) begin
      wr(OFS_CTRL, (i < 2) ? 32'h20 : 32'h00, r);
      fld_weak_i <= (i == 1);
      arm_volt_i <= 16'sd8000;
      arm_cur_i <= 16'sd5000;
      repeat (4) @(posedge clk_sys_i);
      check(av_fb_o, (i == 0) ? 64'd8000 : 64'd7950);
    end
    arm_volt_i <= -16'sd8000;
    tacho_i <= 16'sd3000;
    wr(OFS_LINES, LN, r);
    wr(OFS_MAX_RPM, MAXR, r);
    run <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      wr(OFS_CTRL, {25'h0, ctl[i]}, r);
      wr(OFS_RATIO, (i == 1) ? 32'h2000 : 32'h1000, r);
      quad <= ctl[i][CTRL_QUAD];
      fwd <= fw[i];
      high_ns <= (i == 0) ? 15 : 5000;
      // Model may finish one old-mode cycle; later windows are clean
      repeat (11 * GC / 4) @(posedge clk_sys_i);
      e = sg[i] * (longint'(PULSES) * SEC_PER_MIN * CLK_HZ / GC / LN);
      check(enc_rpm_o, e);
      check(motor_pct_o, pct(e, (i == 1) ? 8192 : 4096));
      check(dir_fwd_o, sg[i] > 0);
      check(dir_pin_free_o, i == 4 || i == 6);
    end
    run <= 1'b0;
    // Long enough to pass the checker's idle limit for zero speed
    repeat (4 * GC) @(posedge clk_sys_i);
    check(enc_rpm_o, 64'h0);
    check(motor_pct_o, 64'h0);
    give_verdict();
  end
endmodule
